// file: dv/clkrst_checker.sv
// Concurrent checks on the ports of the clock and reset generator.
module clkrst_checker #(
  parameter int RST_STRETCH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Inputs
  input wire logic system_reset_in_n,
  input wire logic crystal_in,
  input wire logic pll_supply_ok,
  input wire logic core_supply_ok,
  input wire logic pwm_supply_ok,
  input wire logic pll_cfg_valid,
  input wire logic [3:0] pll_mult,
  input wire logic [3:0] gen_enable,
  // Outputs
  input wire logic oscillator_buffer_out,
  input wire logic reset_indicator_out_n,
  input wire logic sys_reset_n,
  input wire logic pll_enable,
  input wire logic [3:0] pll_mult_out,
  input wire logic pll_bypass,
  input wire logic pwm_clk_sel_pll,
  input wire logic [3:0] gen_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Checks
  // *****
  logic [2:0] age_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Age since reset, so the copy check never looks back into reset history.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  property p_osc; age_r == 3'h7 |-> oscillator_buffer_out == $past(crystal_in, 3); endproperty
  a_osc: assert property (p_osc) else $error("oscillator copy wrong");
  property p_por; !pll_supply_ok [*4] |-> !reset_indicator_out_n; endproperty
  a_por: assert property (p_por) else $error("power-on not shown");
  property p_brown; !(core_supply_ok && pwm_supply_ok) [*4] |-> !reset_indicator_out_n; endproperty
  a_brown: assert property (p_brown) else $error("brown-out not shown");
  property p_ext; !system_reset_in_n [*5] |-> !sys_reset_n; endproperty
  a_ext: assert property (p_ext) else $error("reset input ignored");
  property p_stretch; $rose(sys_reset_n) |-> $past(system_reset_in_n, RST_STRETCH); endproperty
  a_stretch: assert property (p_stretch) else $error("reset released early");
  property p_rst_pll; !sys_reset_n [*3] |-> !pll_enable && pll_bypass; endproperty
  a_rst_pll: assert property (p_rst_pll) else $error("PLL on in reset");
  property p_mult; $rose(pll_enable) |-> pll_mult_out == $past(pll_mult, 2) && pll_mult_out >= 4'h4; endproperty
  a_mult: assert property (p_mult) else $error("factor wrong");
  property p_sel; pwm_clk_sel_pll == !pll_bypass; endproperty
  a_sel: assert property (p_sel) else $error("PWM select wrong");
  property p_cfg; !pll_cfg_valid [*3] |-> pll_bypass; endproperty
  a_cfg: assert property (p_cfg) else $error("bypass missing");
  property p_tick; !gen_enable[2] [*3] |-> !gen_tick[2]; endproperty
  a_tick: assert property (p_tick) else $error("tick while off");
  // Main scenarios reached.
  c_run: cover property ($fell(pll_bypass));
  c_rel: cover property ($rose(sys_reset_n));
  c_ind: cover property ($fell(reset_indicator_out_n));
endmodule
bind clkrst_gen clkrst_checker #(.RST_STRETCH(RST_STRETCH)) chk_u (.core_clk, .rst_n, .system_reset_in_n,
  .crystal_in, .pll_supply_ok, .core_supply_ok, .pwm_supply_ok, .pll_cfg_valid, .pll_mult, .gen_enable,
  .oscillator_buffer_out, .reset_indicator_out_n, .sys_reset_n, .pll_enable, .pll_mult_out, .pll_bypass,
  .pwm_clk_sel_pll, .gen_tick);

// file: dv/clkrst_partner.sv
// Model of the crystal, supply monitors, reset switch and analog PLL lock.
module clkrst_partner (
  // Clock and bench commands
  input wire logic core_clk,
  input wire logic [2:0] sup_drop,
  input wire logic rst_hold,
  input wire logic lock_break,
  input wire logic pll_enable,
  // Pins toward the generator
  output logic crystal_in = 1'b0,
  output logic pll_supply_ok,
  output logic core_supply_ok,
  output logic pwm_supply_ok,
  output logic system_reset_in_n,
  output logic pll_lock_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] lock_cnt = 5'h00;
  // The pin level moves on the falling edge, so the copy path never races the sampling edge.
  always @(negedge core_clk) crystal_in <= ~crystal_in;
  // Supply monitors and the reset switch follow the bench commands directly.
  assign pll_supply_ok = !sup_drop[0];
  assign core_supply_ok = !sup_drop[1];
  assign pwm_supply_ok = !sup_drop[2];
  assign system_reset_in_n = !rst_hold;
  // Lock comes 31 cycles after enable and is lost at once on a commanded break.
  always @(posedge core_clk) begin
    if (!pll_enable) lock_cnt <= 5'h00;
    else if (lock_cnt != 5'h1F) lock_cnt <= lock_cnt + 5'h01;
  end
  assign pll_lock_in = (lock_cnt == 5'h1F) && !lock_break;
endmodule

// file: dv/pll_clock_and_reset_generation_tb_top.sv
// Self-checking bench for the clock and reset generator.
module pll_clock_and_reset_generation_tb_top
  import clkrst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, pll_cfg_valid = 1'b0, rst_hold = 1'b0, lock_break = 1'b0;
  logic [2:0] sup_drop = 3'h0;
  mult_t pll_mult = 4'h4;
  logic [3:0] gen_enable = 4'h0, pll_mult_out, gen_tick;
  logic [7:0] dsp_div = 8'h00, spdif_div = 8'h01, conv_div = 8'h02, mclk_div = 8'h03;
  logic crystal_in, pll_supply_ok, core_supply_ok, pwm_supply_ok, system_reset_in_n, pll_lock_in;
  logic oscillator_buffer_out, reset_indicator_out_n, sys_reset_n, pll_enable, pll_bypass, pwm_clk_sel_pll;
  logic dsp_limit_err;
  int errors = 0, n_checks = 0;
  // 10 MHz reference.
  always #50 core_clk = ~core_clk;
  clkrst_gen #(.RST_STRETCH(8)) dut_u (.core_clk, .rst_n, .system_reset_in_n, .crystal_in, .pll_supply_ok,
    .core_supply_ok, .pwm_supply_ok, .pll_cfg_valid, .pll_mult, .pll_lock_in, .gen_enable, .dsp_div, .spdif_div,
    .conv_div, .mclk_div, .oscillator_buffer_out, .reset_indicator_out_n, .sys_reset_n, .pll_enable,
    .pll_mult_out, .pll_bypass, .pwm_clk_sel_pll, .gen_tick, .dsp_limit_err);
  clkrst_partner partner_u (.core_clk, .sup_drop, .rst_hold, .lock_break, .pll_enable, .crystal_in,
    .pll_supply_ok, .core_supply_ok, .pwm_supply_ok, .system_reset_in_n, .pll_lock_in);
  // *****
  // Shared tasks
  // *****
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Bounded wait; the caller judges the level afterwards.
  task automatic wait_bit(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) step(1);
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_startup();
    wait_bit(sys_reset_n, 1'b1, 40);
    check(8'(sys_reset_n), 8'h1);
    check(8'(pll_bypass), 8'h1);
    check(8'(pll_mult_out), 8'h4);
  endtask
  task automatic t_gen();
    int cnt[4] = '{default: 0};
    gen_enable = 4'hF;
    step(8);
    repeat (24) begin
      for (int b = 0; b < 4; b++) cnt[b] += gen_tick[b];
      step(1);
    end
    for (int b = 0; b < 4; b++) check(8'(cnt[b]), 8'(24 / (b + 1)));
    gen_enable = 4'h0;
    step(4);
    check(8'(gen_tick), 8'h0);
  endtask
  // Factors below 4 must leave the clock bypassed; the cap is checked at 14 and 15.
  task automatic t_pll(input mult_t m, input logic brk);
    pll_mult = m;
    pll_cfg_valid = 1'b1;
    wait_bit(pll_bypass, 1'b0, 400);
    step(2);
    check(8'(pll_bypass), 8'(m < 4'h4));
    check(8'(pll_enable), 8'(m >= 4'h4));
    if (m >= 4'h4) check(8'(pll_mult_out), 8'(m));
    check(8'(pwm_clk_sel_pll), 8'(m >= 4'h4));
    check(8'(dsp_limit_err), 8'(int'(m) * 10000 > 147456));
    // The DSP generator is held off only while the rate is over the ceiling.
    gen_enable = 4'h1;
    step(3);
    check(8'(gen_tick[0]), 8'(int'(m) * 10000 <= 147456));
    // Halving the DSP rate brings every legal factor under the slow ceiling.
    dsp_div = 8'h01;
    step(2);
    check(8'(dsp_limit_err), 8'h0);
    gen_enable = 4'h0;
    dsp_div = 8'h00;
    lock_break = brk;
    step(8);
    check(8'(pll_bypass), 8'(brk || m < 4'h4));
    pll_cfg_valid = 1'b0;
    lock_break = 1'b0;
    step(4);
    check(8'(pll_bypass), 8'h1);
  endtask
  task automatic t_ext_reset();
    int n = 0;
    pll_mult = 4'h8;
    pll_cfg_valid = 1'b1;
    step(5);
    rst_hold = 1'b1;
    step(8);
    check(8'(sys_reset_n), 8'h0);
    check(8'(pll_enable), 8'h0);
    rst_hold = 1'b0;
    while (sys_reset_n !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check(8'(n >= 8 && n <= 14), 8'h1);
    pll_cfg_valid = 1'b0;
  endtask
  task automatic t_supply();
    for (int i = 0; i < 3; i++) begin
      sup_drop = 3'(1 << i);
      step(5);
      check(8'(reset_indicator_out_n), 8'h0);
      if (i == 0) check(8'(sys_reset_n), 8'h0);
      sup_drop = 3'h0;
      step(24);
      check(8'(reset_indicator_out_n), 8'h1);
    end
  endtask
  // Main sequence; reset is held for two cycles.
  initial begin
    step(2);
    rst_n = 1'b1;
    t_startup();
    t_gen();
    t_pll(4'h3, 1'b0);
    t_pll(4'h4, 1'b0);
    t_pll(4'hE, 1'b0);
    t_pll(4'hF, 1'b1);
    t_ext_reset();
    t_supply();
    stop_test();
  end
  // About 1500 cycles are expected, so 20000 means a hang.
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
endmodule

// file: include/clkrst_defs.svh
// Timing counts, limits and reset values for the clock and reset generator.
`ifndef CLKRST_DEFS_SVH
`define CLKRST_DEFS_SVH
// ***********************************************
// Multiplier range and reset values
// ***********************************************
`define PLL_MULT_MIN 4'h4
`define PLL_MULT_MAX 4'hF
`define PLL_MULT_RST 4'h4
// ***********************************************
// Reset stretch and lock timing (core_clk cycles)
// ***********************************************
`define RST_STRETCH_CYCLES 16'h0400
`define LOCK_WAIT_CYCLES 12'h100
// DSP clock ceilings in kHz for the two part grades.
`define DSP_MAX_KHZ_SLOW 32'd147456
`define DSP_MAX_KHZ_FAST 32'd159744
`define REF_KHZ 32'd10000
`endif

// file: include/clkrst_pkg.sv
// Types shared by the clock and reset generator files.
package clkrst_pkg;
  typedef enum logic [1:0] {
    PLL_BYPASS = 2'b00,
    PLL_LOCKING = 2'b01,
    PLL_RUN = 2'b10
  } pll_state_e;
  typedef logic [3:0] mult_t;
endpackage

// file: logic/clk_div.sv
// Programmable divider giving a one-cycle enable pulse every div_sel+1 cycles.
module clk_div (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic [7:0] div_sel,
  // Enable out
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire wrap = (cnt_r >= div_sel);
  assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
  // Counter restarts whenever the generator is disabled.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= wrap;
    end
  end
endmodule

// file: logic/clkrst_gen.sv
// Clock and reset generation: PLL control, bypass, reset combine and stretch, clock enables.
`include "clkrst_defs.svh"
// ***********************************************
// Clock and reset generator
// ***********************************************
// Everything runs on the reference clock; slower clocks are one-cycle enables.
// The analog PLL sits outside: this block only enables it, hands it the factor,
// and switches the PWM timing over once the lock has held long enough.
module clkrst_gen
  import clkrst_pkg::*;
#(
  parameter int RST_STRETCH = `RST_STRETCH_CYCLES,
  parameter logic FAST_GRADE = 1'b0
) (
  // Reference clock and power-on async reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins and supply monitors
  input wire logic system_reset_in_n,
  input wire logic crystal_in,
  input wire logic pll_supply_ok,
  input wire logic core_supply_ok,
  input wire logic pwm_supply_ok,
  // Firmware control
  input wire logic pll_cfg_valid,
  input wire logic [3:0] pll_mult,
  input wire logic pll_lock_in,
  input wire logic [3:0] gen_enable,
  input wire logic [7:0] dsp_div,
  input wire logic [7:0] spdif_div,
  input wire logic [7:0] conv_div,
  input wire logic [7:0] mclk_div,
  // Outputs
  output logic oscillator_buffer_out,
  output logic reset_indicator_out_n,
  output logic sys_reset_n,
  output logic pll_enable,
  output logic [3:0] pll_mult_out,
  output logic pll_bypass,
  output logic pwm_clk_sel_pll,
  output logic [3:0] gen_tick,
  output logic dsp_limit_err
);
  // ***********************************************
  // Input synchronisers
  // ***********************************************
  logic ext_rst_n_s;
  logic pll_ok_s;
  logic core_ok_s;
  logic pwm_ok_s;
  logic xtal_s;
  // Every pin level passes two flip-flops before any logic reads it.
  // The reset value 0 reads as held in reset or supply not yet good,
  // so the block starts out safe until real samples have arrived.
  sync2 #(.RST_VAL(1'b0)) u_sync_rst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(system_reset_in_n),
    .q(ext_rst_n_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_pll (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(pll_supply_ok),
    .q(pll_ok_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_core (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(core_supply_ok),
    .q(core_ok_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_pwm (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(pwm_supply_ok),
    .q(pwm_ok_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_xtal (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(crystal_in),
    .q(xtal_s)
  );

  // ***********************************************
  // Power-on pulse and brown-out
  // ***********************************************
  logic pll_ok_d_r;
  logic por_pulse_r;
  // A rising supply-good level, first or after a droop, gives one pulse.
  wire por_rise = pll_ok_s & ~pll_ok_d_r;
  // Brown-out only drives the pin; it never restarts the internal reset.
  wire brown_out = ~core_ok_s | ~pwm_ok_s;
  // The supply must be good for the pulse to end; while low, power-on is held.
  // The rising edge itself also counts, so the pin does not blink high for
  // one cycle between the supply returning and the registered pulse.
  wire por_active = por_pulse_r | por_rise | ~pll_ok_s;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ok_d_r <= 1'b0;
      por_pulse_r <= 1'b0;
    end else begin
      pll_ok_d_r <= pll_ok_s;
      por_pulse_r <= por_rise;
    end
  end

  // ***********************************************
  // Reset output pin
  // ***********************************************
  // Registered so the pin never glitches on decode.
  wire rst_ind_nxt = ~(por_active | brown_out);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_indicator_out_n <= 1'b0;
    end else begin
      reset_indicator_out_n <= rst_ind_nxt;
    end
  end

  // ***********************************************
  // System reset combine and stretch counter
  // ***********************************************
  // The count runs on the reference clock, which keeps running in reset, so the
  // stretch lasts RST_STRETCH reference periods after the last request ends.
  logic [15:0] stretch_r;
  logic [15:0] stretch_nxt;
  wire rst_req = ~ext_rst_n_s | por_active;
  wire stretch_done = (stretch_r == RST_STRETCH[15:0]);
  assign stretch_nxt = rst_req ? 16'h0000 : (stretch_done ? stretch_r : stretch_r + 16'h0001);
  // Any new request restarts the count, so every release gets the full stretch.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_r <= 16'h0000;
      sys_reset_n <= 1'b0;
    end else begin
      stretch_r <= stretch_nxt;
      sys_reset_n <= ~rst_req & stretch_done;
    end
  end
  // Internal reset as the rest of this block sees it.
  wire in_reset = ~sys_reset_n;

  // ***********************************************
  // PLL control and bypass state machine
  // ***********************************************
  pll_state_e state_r;
  pll_state_e state_nxt;
  logic [11:0] lock_cnt_r;
  logic [3:0] mult_r;
  logic lock_s;
  // The analog lock flag comes from outside the clock domain as well.
  sync2 #(.RST_VAL(1'b0)) u_sync_lock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(pll_lock_in),
    .q(lock_s)
  );
  // State decodes read by the control, the ceiling check and the outputs.
  function automatic logic is_run(input pll_state_e s);
    return (s == PLL_RUN);
  endfunction
  function automatic logic is_bypass(input pll_state_e s);
    return (s == PLL_BYPASS);
  endfunction
  wire run_w = is_run(state_r);
  wire bypass_w = is_bypass(state_r);
  // Out-of-range factors are refused; the PLL stays bypassed until a legal one arrives.
  wire mult_ok = (pll_mult >= `PLL_MULT_MIN) && (pll_mult <= `PLL_MULT_MAX);
  // A request is taken only as a whole: valid together with a legal factor.
  wire cfg_take = pll_cfg_valid && mult_ok;
  wire lock_seen = lock_s && (lock_cnt_r == `LOCK_WAIT_CYCLES);
  // Next-state decode; the spare code falls back to bypass.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PLL_BYPASS: begin
        if (cfg_take) begin
          state_nxt = PLL_LOCKING;
        end
      end
      PLL_LOCKING: begin
        if (!pll_cfg_valid) begin
          state_nxt = PLL_BYPASS;
        end else if (lock_seen) begin
          state_nxt = PLL_RUN;
        end
      end
      PLL_RUN: begin
        if (!pll_cfg_valid || !lock_s) begin
          state_nxt = PLL_BYPASS;
        end
      end
      default: begin
        state_nxt = PLL_BYPASS;
      end
    endcase
  end
  // The factor is latched at the take, so later changes on the pins wait for a new request.
  // The wait filters a lock flag that chatters while the loop is still settling.
  // Lock must hold steadily for the wait count; a drop restarts it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PLL_BYPASS;
      lock_cnt_r <= 12'h000;
      mult_r <= `PLL_MULT_RST;
    end else if (in_reset) begin
      state_r <= PLL_BYPASS;
      lock_cnt_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      if (bypass_w && cfg_take) begin
        mult_r <= pll_mult;
      end
      if (state_r != PLL_LOCKING || !lock_s) begin
        lock_cnt_r <= 12'h000;
      end else if (!lock_seen) begin
        lock_cnt_r <= lock_cnt_r + 12'h001;
      end
    end
  end

  // ***********************************************
  // DSP clock ceiling check
  // ***********************************************
  // Equal rates pass: only a rate strictly above the grade ceiling is refused.
  // Only RUN is checked, because in bypass the DSP runs at the reference.
  // DSP rate = ref * mult / (dsp_div + 1); compare in kHz without dividing.
  wire [31:0] pll_khz = `REF_KHZ * {28'h0, mult_r};
  wire [31:0] dsp_cap = FAST_GRADE ? `DSP_MAX_KHZ_FAST : `DSP_MAX_KHZ_SLOW;
  wire [39:0] cap_scaled = {8'h00, dsp_cap} * {32'h0, dsp_div} + {8'h00, dsp_cap};
  wire dsp_over = ({8'h00, pll_khz} > cap_scaled) && run_w;
  // The DSP generator is held off while the ratio would exceed the grade limit.
  wire [3:0] gen_en_eff = in_reset ? 4'h0 : {gen_enable[3:1], gen_enable[0] & ~dsp_over};

  // ***********************************************
  // Clock generators: DSP, S/PDIF, converter, MCLK
  // ***********************************************
  // Each generator restarts from zero when switched off, so the first tick after an
  // enable comes one full period later and firmware never sees a short first period.
  // The dividers share one clock and differ only in their selection and enable.
  logic [3:0] tick_w;
  wire [7:0] div_sel [4];
  assign div_sel[0] = dsp_div;
  assign div_sel[1] = spdif_div;
  assign div_sel[2] = conv_div;
  assign div_sel[3] = mclk_div;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gen
      clk_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(gen_en_eff[gi]),
        .div_sel(div_sel[gi]),
        .tick(tick_w[gi])
      );
    end
  endgenerate

  // ***********************************************
  // Registered outputs
  // ***********************************************
  // Every top-level output leaves a flip-flop, so nothing downstream sees decode glitches.
  // The oscillator copy is a sampled image, only as fine as the reference clock.
  // Oscillator keeps running in reset, so its copy is never gated.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_buffer_out <= 1'b0;
      pll_enable <= 1'b0;
      pll_mult_out <= `PLL_MULT_RST;
      pll_bypass <= 1'b1;
      pwm_clk_sel_pll <= 1'b0;
      gen_tick <= 4'h0;
      dsp_limit_err <= 1'b0;
    end else begin
      oscillator_buffer_out <= xtal_s;
      pll_enable <= ~in_reset & ~bypass_w;
      pll_mult_out <= mult_r;
      pll_bypass <= ~run_w;
      pwm_clk_sel_pll <= run_w;
      gen_tick <= tick_w;
      dsp_limit_err <= dsp_over;
    end
  end
endmodule

// file: logic/sync2.sv
// Two flip-flop level synchroniser with a constant reset value.
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta_r;
  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
